// file: shared/isa_pkg.sv
// Shared constants and types for the two-wire converter readout block
`default_nettype none

package isa_pkg;

    // ----------------------------------------------------------------
    // Clock and phase timing
    // ----------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 4;
    localparam int          ACQ_TIME_NS   = 1120;
    localparam int          CONV_TIME_NS  = 8960;
    localparam int          RES_BITS      = 12;
    localparam int          CNT_W         = 12;
    localparam logic [11:0] ACQ_CYC       =
        12'((ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] CONV_CYC      = 12'(CONV_TIME_NS / CLK_PERIOD_NS);
    localparam logic [11:0] SLOT_CYC      = 12'(CONV_TIME_NS / CLK_PERIOD_NS / RES_BITS);

    // ----------------------------------------------------------------
    // Addressing and framing
    // ----------------------------------------------------------------
    // Device code value is arbitrary
    localparam logic [3:0]  DEV_CODE         = 4'h6;
    localparam logic [2:0]  ADDR_SEL_DEFAULT = 3'h5;
    localparam logic [3:0]  ADDR_BITS        = 4'h8;
    localparam logic [3:0]  BYTE_LAST        = 4'h7;
    localparam logic [3:0]  PAD_BITS         = 4'h4;
    localparam logic [3:0]  HI_PAD           = 4'h0;
    localparam logic        ACK_LEVEL        = 1'b0;
    localparam logic        RW_READ          = 1'b1;
    localparam logic [11:0] DAC_MSB          = 12'h800;
    localparam logic [3:0]  BIT_TOP          = 4'hb;

    // ----------------------------------------------------------------
    // State encodings
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        BS_IDLE     = 3'h0,
        BS_ADDR     = 3'h1,
        BS_ADDR_ACK = 3'h3,
        BS_TX       = 3'h2,
        BS_TX_ACK   = 3'h6,
        BS_WAIT     = 3'h7
    } isa_bus_state_t;

    typedef enum logic [1:0] {
        CV_IDLE = 2'h0,
        CV_ACQ  = 2'h1,
        CV_CONV = 2'h3
    } isa_conv_state_t;

endpackage

`default_nettype wire

// file: logic/isa_sar_core.sv
// Self-timed acquisition, successive approximation and result holding register
`default_nettype none

module isa_sar_core (
    // Clock and reset
    input  wire  logic        clk,
    input  wire  logic        nrst,
    // Conversion request
    input  wire  logic        start,
    // Analog front end
    input  wire  logic        cmp_above,
    output logic              sample_switch,
    output logic [11:0]       dac_code,
    // Holding register
    output logic [11:0]       result
);

    // ----------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------
    isa_pkg::isa_conv_state_t state_q, state_d;
    logic [11:0]              cnt_q, cnt_d;
    logic [11:0]              slot_q, slot_d;
    logic [3:0]               bit_q, bit_d;
    logic                     fin_q, fin_d;
    logic [11:0]              dac_q, dac_d;
    logic [11:0]              res_q, res_d;
    logic                     samp_q, samp_d;
    logic                     done_q, done_d;

    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        slot_d  = slot_q;
        bit_d   = bit_q;
        fin_d   = fin_q;
        dac_d   = dac_q;
        res_d   = res_q;
        samp_d  = samp_q;
        done_d  = 1'b0;
        case (state_q)
            isa_pkg::CV_IDLE:
            begin
                if (start)
                begin
                    state_d = isa_pkg::CV_ACQ;
                    samp_d  = 1'b1;
                    cnt_d   = '0;
                end
            end
            isa_pkg::CV_ACQ:
            begin
                // Counted on clk only, never on the serial clock
                if (cnt_q == isa_pkg::ACQ_CYC - 12'h001)
                begin
                    state_d = isa_pkg::CV_CONV;
                    samp_d  = 1'b0;
                    cnt_d   = '0;
                    slot_d  = '0;
                    bit_d   = isa_pkg::BIT_TOP;
                    fin_d   = 1'b0;
                    dac_d   = isa_pkg::DAC_MSB;
                end
                else
                begin
                    cnt_d = cnt_q + 12'h001;
                end
            end
            isa_pkg::CV_CONV:
            begin
                cnt_d = cnt_q + 12'h001;
                if (slot_q == isa_pkg::SLOT_CYC - 12'h001)
                begin
                    slot_d = '0;
                    if (!fin_q)
                    begin
                        // Keep or drop the trial bit, then try the next one
                        if (!cmp_above)
                            dac_d[bit_q] = 1'b0;
                        if (bit_q == 4'h0)
                            fin_d = 1'b1;
                        else
                        begin
                            dac_d[bit_q - 4'h1] = 1'b1;
                            bit_d = bit_q - 4'h1;
                        end
                    end
                end
                else
                begin
                    slot_d = slot_q + 12'h001;
                end
                // Whole result lands in one step
                if (cnt_q == isa_pkg::CONV_CYC - 12'h001)
                begin
                    state_d = isa_pkg::CV_IDLE;
                    res_d   = dac_q;
                    done_d  = 1'b1;
                end
            end
            default:
            begin
                state_d = isa_pkg::CV_IDLE;
                samp_d  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= isa_pkg::CV_IDLE;
            cnt_q   <= '0;
            slot_q  <= '0;
            bit_q   <= '0;
            fin_q   <= 1'b0;
            dac_q   <= '0;
            res_q   <= '0;
            samp_q  <= 1'b0;
            done_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            slot_q  <= slot_d;
            bit_q   <= bit_d;
            fin_q   <= fin_d;
            dac_q   <= dac_d;
            res_q   <= res_d;
            samp_q  <= samp_d;
            done_q  <= done_d;
        end
    end

    assign sample_switch = samp_q;
    assign dac_code      = dac_q;
    assign result        = res_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    localparam int ACQ_A  = int'(isa_pkg::ACQ_CYC);
    localparam int CONV_A = int'(isa_pkg::CONV_CYC);

    logic [11:0] conv_len_q;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            conv_len_q <= '0;
        else if (samp_q || done_q)
            conv_len_q <= '0;
        else if (state_q == isa_pkg::CV_CONV)
            conv_len_q <= conv_len_q + 12'h001;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    acq_length_a: assert property ($rose(samp_q) |-> ##ACQ_A $fell(samp_q))
        else $error("acquisition phase length wrong");
    conv_length_a: assert property (done_q |-> int'(conv_len_q) == CONV_A)
        else $error("conversion phase length wrong");
    result_step_a: assert property (!$stable(res_q) |-> done_q)
        else $error("result changed outside conversion end");
    msb_trial_a: assert property ($fell(samp_q) |-> dac_q == isa_pkg::DAC_MSB)
        else $error("conversion did not start at msb trial");

endmodule

`default_nettype wire

// file: logic/isa_readout.sv
// Two-wire serial slave readout around the successive approximation core
//
// How it works
// - Data line changes only while serial clock is low, for both parties.
// - Data transition while clock high is start or stop, never data.
// - After acquisition open sample switch, resolve result by successive approximation.
// - Each conversion result is kept in a 12-bit register, readable anytime.
// - Result shifts out most significant bit first, unsigned binary.
// - Conversion phase after switch opens lasts 8.96 microseconds.
// - Conversion timing comes from internal clock, independent of serial clock.
// - Acquisition lasts 1.12 microseconds, timed by internal clock.
// - Transaction is start, address byte, two data bytes, master stop.
// - Master acknowledge after second byte triggers another conversion, 18 clocks each.
// - Slave address is 4-bit device code plus three select bits, default 101.
// - Write bit zero: acknowledge, release bus, start no conversion.
// - First byte four zeros plus upper nibble; second byte lower eight bits.
`default_nettype none

module isa_readout #(
    parameter logic [2:0] ADDR_SEL = isa_pkg::ADDR_SEL_DEFAULT
) (
    // Clock and reset
    input  wire  logic        clk,
    input  wire  logic        nrst,
    // Serial bus, open drain data
    input  wire  logic        scl,
    input  wire  logic        sda_in,
    output logic              sda_out,
    output logic              sda_oe,
    // Analog front end
    input  wire  logic        cmp_above,
    output logic              sample_switch,
    output logic [11:0]       dac_code,
    // Holding register
    output logic [11:0]       result
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [2:0] scl_sync_q, scl_sync_d;
    logic [2:0] sda_sync_q, sda_sync_d;

    always_comb
    begin
        // Stage 0 feeds stage 1 only; stage 2 keeps history
        scl_sync_d = {scl_sync_q[1:0], scl};
        sda_sync_d = {sda_sync_q[1:0], sda_in};
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            scl_sync_q <= '1;
            sda_sync_q <= '1;
        end
        else
        begin
            scl_sync_q <= scl_sync_d;
            sda_sync_q <= sda_sync_d;
        end
    end

    logic scl_now;
    logic scl_prev;
    logic sda_now;
    logic sda_prev;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic frame_cond;

    assign scl_now    = scl_sync_q[1];
    assign scl_prev   = scl_sync_q[2];
    assign sda_now    = sda_sync_q[1];
    assign sda_prev   = sda_sync_q[2];
    assign scl_rise   = scl_now & ~scl_prev;
    assign scl_fall   = ~scl_now & scl_prev;
    // Data moving under a high clock is framing only
    assign start_cond = scl_now & scl_prev & sda_prev & ~sda_now;
    assign stop_cond  = scl_now & scl_prev & ~sda_prev & sda_now;
    assign frame_cond = start_cond | stop_cond;

    // ----------------------------------------------------------------
    // Bus state machine
    // ----------------------------------------------------------------
    isa_pkg::isa_bus_state_t st_q, st_d;
    logic [3:0]              cnt_q, cnt_d;
    logic [7:0]              sh_q, sh_d;
    logic [7:0]              tx_q, tx_d;
    logic [11:0]             snap_q, snap_d;
    logic                    low_q, low_d;
    logic                    rw_q, rw_d;
    logic                    ack_q, ack_d;
    logic                    oe_q, oe_d;
    logic                    out_q, out_d;
    logic                    conv_start_q, conv_start_d;
    logic [11:0]             result_w;

    always_comb
    begin
        st_d         = st_q;
        cnt_d        = cnt_q;
        sh_d         = sh_q;
        tx_d         = tx_q;
        snap_d       = snap_q;
        low_d        = low_q;
        rw_d         = rw_q;
        ack_d        = ack_q;
        oe_d         = oe_q;
        out_d        = 1'b0;
        conv_start_d = 1'b0;
        if (stop_cond)
        begin
            // Stop ends any transaction and frees the line
            st_d = isa_pkg::BS_IDLE;
            oe_d = 1'b0;
        end
        else if (start_cond)
        begin
            st_d  = isa_pkg::BS_ADDR;
            cnt_d = '0;
            oe_d  = 1'b0;
        end
        else
        begin
            case (st_q)
                isa_pkg::BS_IDLE:
                begin
                    oe_d = 1'b0;
                end
                isa_pkg::BS_ADDR:
                begin
                    if (scl_rise)
                    begin
                        sh_d  = {sh_q[6:0], sda_now};
                        cnt_d = cnt_q + 4'h1;
                    end
                    else if (scl_fall && cnt_q == isa_pkg::ADDR_BITS)
                    begin
                        // Match device code and select bits
                        if (sh_q[7:1] == {isa_pkg::DEV_CODE, ADDR_SEL})
                        begin
                            st_d         = isa_pkg::BS_ADDR_ACK;
                            oe_d         = 1'b1;
                            rw_d         = sh_q[0];
                            // Writes only get an acknowledge
                            conv_start_d = (sh_q[0] == isa_pkg::RW_READ);
                        end
                        else
                        begin
                            st_d = isa_pkg::BS_WAIT;
                        end
                    end
                end
                isa_pkg::BS_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (rw_q == isa_pkg::RW_READ)
                        begin
                            // Freeze a whole result for this pair
                            snap_d = result_w;
                            tx_d   = {isa_pkg::HI_PAD, result_w[11:8]};
                            low_d  = 1'b0;
                            cnt_d  = '0;
                            st_d   = isa_pkg::BS_TX;
                            oe_d   = ~isa_pkg::HI_PAD[3];
                        end
                        else
                        begin
                            st_d = isa_pkg::BS_WAIT;
                            oe_d = 1'b0;
                        end
                    end
                end
                isa_pkg::BS_TX:
                begin
                    if (scl_fall)
                    begin
                        if (cnt_q == isa_pkg::BYTE_LAST)
                        begin
                            st_d  = isa_pkg::BS_TX_ACK;
                            oe_d  = 1'b0;
                            ack_d = ~isa_pkg::ACK_LEVEL;
                        end
                        else
                        begin
                            // Drive changes only right after a clock fall
                            tx_d  = {tx_q[6:0], 1'b0};
                            oe_d  = ~tx_q[6];
                            cnt_d = cnt_q + 4'h1;
                        end
                    end
                end
                isa_pkg::BS_TX_ACK:
                begin
                    if (scl_rise)
                    begin
                        ack_d = sda_now;
                    end
                    else if (scl_fall)
                    begin
                        if (ack_q == isa_pkg::ACK_LEVEL)
                        begin
                            if (!low_q)
                            begin
                                tx_d  = snap_q[7:0];
                                low_d = 1'b1;
                            end
                            else
                            begin
                                // Acknowledged second byte: convert again
                                snap_d       = result_w;
                                tx_d         = {isa_pkg::HI_PAD, result_w[11:8]};
                                low_d        = 1'b0;
                                conv_start_d = 1'b1;
                            end
                            st_d  = isa_pkg::BS_TX;
                            cnt_d = '0;
                            oe_d  = ~tx_d[7];
                        end
                        else
                        begin
                            // No acknowledge: release and wait for stop
                            st_d = isa_pkg::BS_WAIT;
                            oe_d = 1'b0;
                        end
                    end
                end
                isa_pkg::BS_WAIT:
                begin
                    oe_d = 1'b0;
                end
                default:
                begin
                    st_d = isa_pkg::BS_IDLE;
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_q         <= isa_pkg::BS_IDLE;
            cnt_q        <= '0;
            sh_q         <= '0;
            tx_q         <= '0;
            snap_q       <= '0;
            low_q        <= 1'b0;
            rw_q         <= 1'b0;
            ack_q        <= 1'b1;
            oe_q         <= 1'b0;
            out_q        <= 1'b0;
            conv_start_q <= 1'b0;
        end
        else
        begin
            st_q         <= st_d;
            cnt_q        <= cnt_d;
            sh_q         <= sh_d;
            tx_q         <= tx_d;
            snap_q       <= snap_d;
            low_q        <= low_d;
            rw_q         <= rw_d;
            ack_q        <= ack_d;
            oe_q         <= oe_d;
            out_q        <= out_d;
            conv_start_q <= conv_start_d;
        end
    end

    assign sda_out = out_q;
    assign sda_oe  = oe_q;
    assign result  = result_w;

    // ----------------------------------------------------------------
    // Converter core
    // ----------------------------------------------------------------
    isa_sar_core u_core (
        .clk           (clk),
        .nrst          (nrst),
        .start         (conv_start_q),
        .cmp_above     (cmp_above),
        .sample_switch (sample_switch),
        .dac_code      (dac_code),
        .result        (result_w)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence second_byte_acked;
        st_q == isa_pkg::BS_TX_ACK && scl_fall && !stop_cond && !start_cond &&
        ack_q == isa_pkg::ACK_LEVEL && low_q;
    endsequence

    sequence pair_reloaded;
        st_q == isa_pkg::BS_TX && !low_q && cnt_q == 4'h0;
    endsequence

    start_enter_a: assert property (
        start_cond && !stop_cond |=> st_q == isa_pkg::BS_ADDR && !oe_q)
        else $error("start not taken");
    stop_release_a: assert property (stop_cond |=> st_q == isa_pkg::BS_IDLE && !oe_q)
        else $error("stop did not release bus");
    drive_scl_low_a: assert property (
        $changed(oe_q) && !$past(frame_cond) |-> !$past(scl_now))
        else $error("data drive changed with clock high");
    poll_no_conv_a: assert property (conv_start_q |-> rw_q == isa_pkg::RW_READ)
        else $error("conversion started on write address");
    zero_nibble_a: assert property (
        st_q == isa_pkg::BS_TX && !low_q && cnt_q < isa_pkg::PAD_BITS |-> oe_q)
        else $error("upper pad bit not zero");
    msb_first_a: assert property (st_q == isa_pkg::BS_TX |-> oe_q == ~tx_q[7])
        else $error("output bit is not shift msb");
    snap_stable_a: assert property (
        st_q == isa_pkg::BS_TX && $past(st_q) == isa_pkg::BS_TX |-> $stable(snap_q))
        else $error("result changed during readout");
    cont_conv_a: assert property (
        second_byte_acked |=> conv_start_q ##0 pair_reloaded)
        else $error("acknowledged pair did not restart conversion");

endmodule

`default_nettype wire

// file: sim/isa_bus_master.sv
// Behavioural two-wire bus master that reads the converter
`default_nettype none

module isa_bus_master #(
    parameter int HALF = 80
) (
    // Clock
    input  wire  logic       clk,
    // Serial bus, open drain data
    output logic             scl,
    output logic             sda_oe,
    input  wire  logic       sda,
    // Address acknowledge bit and each data byte seen
    output logic             rpt,
    output logic [7:0]       rpt_val
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        scl     = 1'b1;
        sda_oe  = 1'b0;
        rpt     = 1'b0;
        rpt_val = 8'h00;
    end

    task automatic wait_half();
        repeat (HALF) @(posedge clk);
    endtask

    // Data moves one clk after the clock fell (two after a byte report), never with the clock high
    task automatic bit_io(input logic b, output logic r);
        @(posedge clk);
        sda_oe <= ~b;
        wait_half();
        scl <= 1'b1;
        wait_half();
        r = sda;
        scl <= 1'b0;
    endtask

    task automatic note(input logic [7:0] v);
        rpt_val <= v;
        rpt     <= 1'b1;
        @(posedge clk);
        rpt     <= 1'b0;
    endtask

    // Start, address, pairs of bytes, no acknowledge on the last, stop
    task automatic frame(input logic [7:0] adr, input int pairs);
        logic       r;
        logic [7:0] d;
        sda_oe <= 1'b1;
        wait_half();
        scl <= 1'b0;
        for (int i = 7; i >= 0; i--) bit_io(adr[i], r);
        bit_io(1'b1, r);
        note({7'h00, r});
        for (int p = 0; p < pairs; p++)
            for (int k = 0; k < 2; k++)
            begin
                for (int i = 7; i >= 0; i--)
                begin
                    bit_io(1'b1, r);
                    d[i] = r;
                end
                note(d);
                bit_io((p == pairs - 1) && (k == 1), r);
            end
        @(posedge clk);
        sda_oe <= 1'b1;
        wait_half();
        scl <= 1'b1;
        wait_half();
        sda_oe <= 1'b0;
        wait_half();
    endtask
endmodule

`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the two-wire converter readout
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [2:0] SEL = isa_pkg::ADDR_SEL_DEFAULT;

    logic        clk = 1'b0;
    logic        nrst;
    logic        scl;
    logic        m_oe;
    logic        d_oe;
    logic        d_out;
    logic        sw;
    logic        cmp = 1'b0;
    logic        rpt;
    logic [7:0]  rpt_val;
    logic [11:0] dac;
    logic [11:0] res;
    logic [11:0] res_prev = 12'h000;
    logic [11:0] vin;
    logic [11:0] last;
    logic [7:0]  exp_q[$];
    int          n_fail;
    int          num_checks;
    int          cyc = 0;
    int          acq_n = 0;
    int          t_open = 0;
    // Open-drain data line with pull-up: low if either side pulls it low
    wire         sda = ~m_oe & (d_oe ? d_out : 1'b1);

    isa_readout #(.ADDR_SEL(SEL)) DUT (
        .clk(clk), .nrst(nrst), .scl(scl), .sda_in(sda), .sda_out(d_out), .sda_oe(d_oe),
        .cmp_above(cmp), .sample_switch(sw), .dac_code(dac), .result(res)
    );

    isa_bus_master #(.HALF(80)) u_mst (
        .clk(clk), .scl(scl), .sda_oe(m_oe), .sda(sda), .rpt(rpt), .rpt_val(rpt_val)
    );

    always #2 clk = ~clk;

    // --------------------------------------------------------------------
    // Checking
    // --------------------------------------------------------------------
    task automatic check(input logic [11:0] e, input logic [11:0] g);
        num_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    task automatic give_verdict();
        if (n_fail == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk)
        if (rpt)
            check({4'h0, exp_q.pop_front()}, {4'h0, rpt_val});

    // Analog input modelled half a step above vin, so the result equals vin
    always @(posedge clk)
    begin
        cmp      <= (vin >= dac);
        cyc      <= cyc + 1;
        acq_n    <= sw ? acq_n + 1 : 0;
        res_prev <= res;
        if (!sw && acq_n != 0)
        begin
            t_open <= cyc;
            check(isa_pkg::ACQ_CYC, 12'(acq_n));
        end
        if (nrst && res !== res_prev)
            check(isa_pkg::CONV_CYC, 12'(cyc - t_open));
        if (cyc == 90000)
        begin
            n_fail++;
            give_verdict();
        end
    end

    // --------------------------------------------------------------------
    // Stimulus
    // --------------------------------------------------------------------
    task automatic xfer(input logic [2:0] sel, input logic rw, input int pairs);
        logic [11:0] v;
        exp_q.push_back({7'h00, sel != SEL});
        for (int p = 0; p < pairs; p++)
        begin
            v = (p == 0) ? last : vin;
            exp_q.push_back({4'h0, v[11:8]});
            exp_q.push_back(v[7:0]);
        end
        u_mst.frame({isa_pkg::DEV_CODE, sel, rw}, pairs);
    endtask

    initial
    begin
        nrst       = 1'b0;
        vin        = 12'h000;
        last       = 12'h000;
        n_fail     = 0;
        num_checks = 0;
        void'($urandom(69));
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (5) @(posedge clk);
        for (int i = 0; i < 4; i++)
        begin
            vin <= (i == 0) ? 12'hfff : (i == 1) ? 12'h000 : 12'($urandom());
            @(posedge clk);
            xfer(SEL, 1'b1, 2);
            repeat (100) @(posedge clk);
            check(vin, res);
            last = vin;
        end
        vin <= ~last;
        xfer(SEL, 1'b0, 0);
        xfer(SEL ^ 3'h2, 1'b1, 0);
        repeat (3000) @(posedge clk);
        check(last, res);
        give_verdict();
    end
endmodule

`default_nettype wire
